/* File: logic/apmc_regs.sv */
// What this block does
// RULE_01: Reset bit starts soft reset, self-clears.
// RULE_02: Auto-increment bit lets accesses cross pages.
// RULE_03: Path selector picks playback and sense path.
// RULE_04: Tracking bit zero selects class H boost.
// RULE_05: Tracking bit one selects class G boost.
// RULE_06: Gain field sets 0 to 15 dB.
// RULE_07: Power field selects down, boost, no-boost.
// RULE_08: Fault power-down shows in power field.
// RULE_09: Fault flag reads one after an error.
// RULE_10: Sense mute bits mute current, voltage sense.
// RULE_11: Playback mute bit mutes audio pop-free.
// RULE_12: Host writes reserved bits only as reset.
`timescale 1ns/1ps
module apmc_regs import apmc_pkg::*; (
	input wire logic clock_i,
	input wire logic sys_rst_i,
	input wire logic scl_i,
	input wire logic sda_i,
	output logic sda_o,
	output logic sda_oe_o,
	input wire logic fault_i,
	output logic soft_reset_o,
	output logic [7:0] page_o,
	output logic [2:0] path_select_o,
	output logic boost_tracking_select_o,
	output logic [3:0] dac_gain_o,
	output logic [1:0] power_state_select_o,
	output logic power_fault_flag_o,
	output logic current_sense_mute_o,
	output logic voltage_sense_mute_o,
	output logic playback_mute_o
);
	logic [7:0] page_r, mode_r, spk_r, pwr2_r, pwr1_r, rd_data, ptr;
	logic [7:0] wr_addr, wr_data, pwr1_nxt;
	logic srst_r, flt_m_r, flt_s_r, wr_stb, wrap, wr_p0, rst_all;

	apmc_i2c_port u_port (
		.clock_i(clock_i),
		.sys_rst_i(sys_rst_i),
		.scl_i(scl_i),
		.sda_i(sda_i),
		.sda_o(sda_o),
		.sda_oe_o(sda_oe_o),
		.rd_data_i(rd_data),
		.ptr_o(ptr),
		.wr_stb_o(wr_stb),
		.wr_addr_o(wr_addr),
		.wr_data_o(wr_data),
		.wrap_o(wrap)
	);

	// Control registers live on page zero; the page register is on all.
	assign wr_p0 = wr_stb && page_r == APMC_RST_PAGE;
	assign rst_all = sys_rst_i | srst_r;

	// The fault line comes from the analog side, so it is synchronised.
	always_ff @(posedge clock_i) begin
		if (sys_rst_i) begin
			flt_m_r <= 1'b0;
			flt_s_r <= 1'b0;
		end else begin
			flt_m_r <= fault_i;
			flt_s_r <= flt_m_r;
		end
	end

	// One-cycle soft reset; the bit never stores, so it reads as zero.
	always_ff @(posedge clock_i) begin
		if (rst_all) begin
			srst_r <= 1'b0;
		end else begin
			srst_r <= wr_p0 && wr_addr == APMC_OFS_RESET &&
				wr_data[APMC_BIT_SRST]; // RULE_01
		end
	end

	// Page select, advanced by the port when the pointer wraps.
	always_ff @(posedge clock_i) begin
		if (rst_all) begin
			page_r <= APMC_RST_PAGE;
		end else if (wr_stb && wr_addr == APMC_OFS_PAGE) begin
			page_r <= wr_data;
		end else if (wrap && mode_r[APMC_BIT_PAGE_AUTO_INCREMENT]) begin
			page_r <= page_r + 8'h01; // RULE_02
		end
	end

	// An illegal path code is dropped so the data path never sees it.
	always_ff @(posedge clock_i) begin
		if (rst_all) begin
			mode_r <= APMC_RST_MODE;
		end else if (wr_p0 && wr_addr == APMC_OFS_MODE) begin
			mode_r[7:APMC_PATH_MSB+1] <= wr_data[7:APMC_PATH_MSB+1];
			if (wr_data[APMC_PATH_MSB:0] >= APMC_PATH_PCM &&
				wr_data[APMC_PATH_MSB:0] <= APMC_PATH_PDM_PDM) begin
				mode_r[APMC_PATH_MSB:0] <= wr_data[APMC_PATH_MSB:0]; // RULE_03
			end
		end
	end

	// Boost tracking and gain are stored as written and drive out directly.
	always_ff @(posedge clock_i) begin
		if (rst_all) begin
			spk_r <= APMC_RST_SPK;
		end else if (wr_p0 && wr_addr == APMC_OFS_SPK) begin
			spk_r <= wr_data; // RULE_04 RULE_05 RULE_06
		end
	end

	// Power state and mutes; a fault overrides a host write of the power state, not of the mutes.
	always_comb begin
		pwr1_nxt = pwr1_r;
		if (wr_p0 && wr_addr == APMC_OFS_PWR1) begin
			pwr1_nxt[APMC_PWR_LSB-1:0] = wr_data[APMC_PWR_LSB-1:0]; // RULE_10
			if (wr_data[APMC_PWR_MSB:APMC_PWR_LSB] != APMC_PWR_ILLEGAL) begin
				pwr1_nxt[APMC_PWR_MSB:APMC_PWR_LSB] =
					wr_data[APMC_PWR_MSB:APMC_PWR_LSB]; // RULE_07
			end
		end
		if (flt_s_r) begin
			pwr1_nxt[APMC_PWR_MSB:APMC_PWR_LSB] = APMC_PWR_DOWN; // RULE_08
		end
	end

	always_ff @(posedge clock_i) begin
		if (rst_all) begin
			pwr1_r <= APMC_RST_PWR1;
		end else begin
			pwr1_r <= pwr1_nxt; // RULE_11
		end
	end

	// Fault flag: set wins over a host clear in the same cycle.
	always_ff @(posedge clock_i) begin
		if (rst_all) begin
			pwr2_r <= APMC_RST_PWR2;
		end else begin
			if (wr_p0 && wr_addr == APMC_OFS_PWR2) begin
				pwr2_r <= wr_data;
			end
			if (flt_s_r) begin
				pwr2_r[APMC_BIT_ERR] <= 1'b1; // RULE_09
			end
		end
	end

	// Read mux feeding the serial port; unmapped offsets read zero.
	always_comb begin
		rd_data = 8'h00;
		if (ptr == APMC_OFS_PAGE) begin
			rd_data = page_r;
		end else if (page_r == APMC_RST_PAGE) begin
			unique case (ptr)
			APMC_OFS_MODE: rd_data = mode_r;
			APMC_OFS_SPK: rd_data = spk_r;
			APMC_OFS_PWR2: rd_data = pwr2_r;
			APMC_OFS_PWR1: rd_data = pwr1_r;
			default: rd_data = 8'h00;
			endcase
		end
	end

	// Outputs are register slices, so each comes straight from a flop.
	assign soft_reset_o = srst_r;
	assign page_o = page_r;
	assign path_select_o = mode_r[APMC_PATH_MSB:0];
	assign boost_tracking_select_o = spk_r[APMC_BIT_BST_SEL];
	assign dac_gain_o = spk_r[APMC_GAIN_MSB:0];
	assign power_state_select_o = pwr1_r[APMC_PWR_MSB:APMC_PWR_LSB];
	assign power_fault_flag_o = pwr2_r[APMC_BIT_ERR];
	assign current_sense_mute_o = pwr1_r[APMC_BIT_MUTE_I];
	assign voltage_sense_mute_o = pwr1_r[APMC_BIT_MUTE_V];
	assign playback_mute_o = pwr1_r[APMC_BIT_MUTE_A];

	default clocking cb @(posedge clock_i);
	endclocking
	default disable iff (sys_rst_i);

	sequence s_srst_req;
		wr_p0 && wr_addr == APMC_OFS_RESET && wr_data[APMC_BIT_SRST];
	endsequence
	sequence s_srst_done;
		soft_reset_o ##1 (!soft_reset_o && spk_r == APMC_RST_SPK);
	endsequence

	AST_SRST_SELF_CLEAR: assert property (s_srst_req |=> s_srst_done) // RULE_01
		else $error("soft reset did not pulse and clear");
	AST_PAGE_ADV: assert property (wrap && mode_r[APMC_BIT_PAGE_AUTO_INCREMENT] && // RULE_02
		!(wr_stb && wr_addr == APMC_OFS_PAGE) && !srst_r |=>
		page_r == $past(page_r) + 8'h01)
		else $error("page did not advance on wrap");
	AST_PAGE_HOLD: assert property (wrap && !mode_r[APMC_BIT_PAGE_AUTO_INCREMENT] && // RULE_02
		!srst_r |=> page_r == $past(page_r))
		else $error("page moved with auto-increment off");
	AST_PATH_LEGAL: assert property (path_select_o >= APMC_PATH_PCM && // RULE_03
		path_select_o <= APMC_PATH_PDM_PDM)
		else $error("illegal data path code");
	AST_CLASS_H: assert property (wr_p0 && wr_addr == APMC_OFS_SPK && // RULE_04
		!wr_data[APMC_BIT_BST_SEL] && !srst_r |=> !boost_tracking_select_o)
		else $error("class H not selected");
	AST_CLASS_G: assert property (wr_p0 && wr_addr == APMC_OFS_SPK && // RULE_05
		wr_data[APMC_BIT_BST_SEL] && !srst_r |=> boost_tracking_select_o)
		else $error("class G not selected");
	AST_GAIN: assert property (wr_p0 && wr_addr == APMC_OFS_SPK && // RULE_06
		!srst_r |=> dac_gain_o == $past(wr_data[APMC_GAIN_MSB:0]))
		else $error("gain not taken");
	AST_PWR_LEGAL: assert property (power_state_select_o != APMC_PWR_ILLEGAL) // RULE_07
		else $error("illegal power state");
	AST_FAULT_DOWN: assert property (flt_s_r && !srst_r |=> // RULE_08
		power_state_select_o == APMC_PWR_DOWN && power_fault_flag_o) // RULE_09
		else $error("fault did not power down and flag");
	AST_MUTES: assert property (wr_p0 && wr_addr == APMC_OFS_PWR1 && // RULE_10
		!srst_r |=> {current_sense_mute_o, voltage_sense_mute_o,
		playback_mute_o} == $past(wr_data[APMC_BIT_MUTE_I:0])) // RULE_11
		else $error("mute bits not taken");

endmodule

/* File: logic/apmc_pkg.sv */
package apmc_pkg;

	// Register offsets inside the control page.
	localparam logic [7:0] APMC_OFS_PAGE = 8'h00;
	localparam logic [7:0] APMC_OFS_RESET = 8'h01;
	localparam logic [7:0] APMC_OFS_MODE = 8'h02;
	localparam logic [7:0] APMC_OFS_SPK = 8'h04;
	localparam logic [7:0] APMC_OFS_PWR2 = 8'h05;
	localparam logic [7:0] APMC_OFS_PWR1 = 8'h07;

	// Reset values.
	localparam logic [7:0] APMC_RST_PAGE = 8'h00;
	localparam logic [7:0] APMC_RST_MODE = 8'h01;
	localparam logic [7:0] APMC_RST_SPK = 8'h5F;
	localparam logic [7:0] APMC_RST_PWR2 = 8'h00;
	localparam logic [7:0] APMC_RST_PWR1 = 8'h00;

	// Field positions.
	localparam int APMC_BIT_SRST = 0;
	localparam int APMC_BIT_PAGE_AUTO_INCREMENT = 7;
	localparam int APMC_PATH_MSB = 2;
	localparam int APMC_BIT_BST_SEL = 4;
	localparam int APMC_GAIN_MSB = 3;
	localparam int APMC_PWR_MSB = 7;
	localparam int APMC_PWR_LSB = 6;
	localparam int APMC_BIT_MUTE_I = 2;
	localparam int APMC_BIT_MUTE_V = 1;
	localparam int APMC_BIT_MUTE_A = 0;
	localparam int APMC_BIT_ERR = 0;

	// Data path codes; 0, 6 and 7 are not legal.
	localparam logic [2:0] APMC_PATH_PCM = 3'h1;
	localparam logic [2:0] APMC_PATH_PDM_PDM = 3'h5;

	// Power state codes; 3 is not legal.
	localparam logic [1:0] APMC_PWR_DOWN = 2'h0;
	localparam logic [1:0] APMC_PWR_BOOST = 2'h1;
	localparam logic [1:0] APMC_PWR_NOBOOST = 2'h2;
	localparam logic [1:0] APMC_PWR_ILLEGAL = 2'h3;

	// Serial control port; the target address value is arbitrary.
	localparam logic [6:0] APMC_DEV_ADDR = 7'h2A;
	localparam logic [3:0] APMC_BITS_BYTE = 4'h8;
	localparam logic [7:0] APMC_PTR_LAST = 8'h7F;

	typedef enum logic [6:0] {
		APMC_ST_IDLE = 7'h01,
		APMC_ST_ADDR = 7'h02,
		APMC_ST_ACK_ADDR = 7'h04,
		APMC_ST_REG = 7'h08,
		APMC_ST_WDATA = 7'h10,
		APMC_ST_ACK_WR = 7'h20,
		APMC_ST_RDATA = 7'h40
	} apmc_state_t;

endpackage

/* File: logic/apmc_i2c_port.sv */
`timescale 1ns/1ps
module apmc_i2c_port import apmc_pkg::*; (
	input wire logic clock_i,
	input wire logic sys_rst_i,
	input wire logic scl_i,
	input wire logic sda_i,
	output logic sda_o,
	output logic sda_oe_o,
	input wire logic [7:0] rd_data_i,
	output logic [7:0] ptr_o,
	output logic wr_stb_o,
	output logic [7:0] wr_addr_o,
	output logic [7:0] wr_data_o,
	output logic wrap_o
);
	logic scl_m_r, scl_s_r, scl_d_r, sda_m_r, sda_s_r, sda_d_r;
	logic scl_rise, scl_fall, start_det, stop_det;
	apmc_state_t state_r;
	logic host_ack_r;
	logic [3:0] cnt_r;
	logic [7:0] sh_r;
	logic rw_r, nack_r, oe_r, wr_stb_r, wrap_r;
	logic [7:0] ptr_r, wr_addr_r, wr_data_r, ptr_inc;

	// Both bus pins come from another party, so each passes two flops.
	always_ff @(posedge clock_i) begin
		if (sys_rst_i) begin
			scl_m_r <= 1'b1;
			scl_s_r <= 1'b1;
			scl_d_r <= 1'b1;
			sda_m_r <= 1'b1;
			sda_s_r <= 1'b1;
			sda_d_r <= 1'b1;
		end else begin
			scl_m_r <= scl_i;
			scl_s_r <= scl_m_r;
			scl_d_r <= scl_s_r;
			sda_m_r <= sda_i;
			sda_s_r <= sda_m_r;
			sda_d_r <= sda_s_r;
		end
	end

	// Edge and frame detection on the synchronised copies only.
	assign scl_rise = scl_s_r & ~scl_d_r;
	assign scl_fall = ~scl_s_r & scl_d_r;
	assign start_det = scl_s_r & scl_d_r & ~sda_s_r & sda_d_r;
	assign stop_det = scl_s_r & scl_d_r & sda_s_r & ~sda_d_r;
	assign ptr_inc = (ptr_r == APMC_PTR_LAST) ? 8'h00 : ptr_r + 8'h01;

	// Byte engine; data changes only while the clock is low.
	always_ff @(posedge clock_i) begin
		if (sys_rst_i) begin
			state_r <= APMC_ST_IDLE;
			host_ack_r <= 1'b0;
			cnt_r <= 4'h0;
			sh_r <= 8'h00;
			rw_r <= 1'b0;
			nack_r <= 1'b0;
			oe_r <= 1'b0;
			ptr_r <= 8'h00;
			wr_stb_r <= 1'b0;
			wr_addr_r <= 8'h00;
			wr_data_r <= 8'h00;
			wrap_r <= 1'b0;
		end else begin
			wr_stb_r <= 1'b0;
			wrap_r <= 1'b0;
			if (start_det) begin
				state_r <= APMC_ST_ADDR;
				host_ack_r <= 1'b0;
				cnt_r <= 4'h0;
				oe_r <= 1'b0;
			end else if (stop_det) begin
				state_r <= APMC_ST_IDLE;
				host_ack_r <= 1'b0;
				oe_r <= 1'b0;
			end else begin
				unique case (state_r)
				APMC_ST_IDLE: begin
					oe_r <= 1'b0;
				end
				APMC_ST_ADDR, APMC_ST_REG, APMC_ST_WDATA: begin
					if (scl_rise) begin
						sh_r <= {sh_r[6:0], sda_s_r};
						cnt_r <= cnt_r + 4'h1;
					end else if (scl_fall && cnt_r == APMC_BITS_BYTE) begin
						cnt_r <= 4'h0;
						oe_r <= 1'b1;
						state_r <= APMC_ST_ACK_WR;
						if (state_r == APMC_ST_ADDR) begin
							rw_r <= sh_r[0];
							state_r <= APMC_ST_ACK_ADDR;
							if (sh_r[7:1] != APMC_DEV_ADDR) begin
								oe_r <= 1'b0;
								state_r <= APMC_ST_IDLE;
							end
						end else if (state_r == APMC_ST_REG) begin
							ptr_r <= sh_r;
						end else begin
							wr_stb_r <= 1'b1;
							wr_addr_r <= ptr_r;
							wr_data_r <= sh_r;
							ptr_r <= ptr_inc;
							wrap_r <= (ptr_r == APMC_PTR_LAST);
						end
					end
				end
				APMC_ST_ACK_ADDR: begin
					if (scl_fall) begin
						cnt_r <= 4'h0;
						if (rw_r) begin
							sh_r <= rd_data_i;
							oe_r <= ~rd_data_i[7];
							state_r <= APMC_ST_RDATA;
						end else begin
							oe_r <= 1'b0;
							state_r <= APMC_ST_REG;
						end
					end
				end
				APMC_ST_ACK_WR: begin
					if (scl_fall) begin
						oe_r <= 1'b0;
						state_r <= APMC_ST_WDATA;
					end
				end
				APMC_ST_RDATA: begin
					// The host acknowledge slot follows the eighth bit.
					if (scl_rise && host_ack_r) begin
						nack_r <= sda_s_r;
					end else if (scl_rise) begin
						cnt_r <= cnt_r + 4'h1;
					end else if (scl_fall && host_ack_r) begin
						host_ack_r <= 1'b0;
						cnt_r <= 4'h0;
						if (!nack_r) begin
							sh_r <= rd_data_i;
							oe_r <= ~rd_data_i[7];
						end else begin
							state_r <= APMC_ST_IDLE;
						end
					end else if (scl_fall && cnt_r == APMC_BITS_BYTE) begin
						oe_r <= 1'b0;
						host_ack_r <= 1'b1;
						ptr_r <= ptr_inc;
						wrap_r <= (ptr_r == APMC_PTR_LAST);
					end else if (scl_fall) begin
						sh_r <= {sh_r[6:0], 1'b0};
						oe_r <= ~sh_r[6];
					end
				end
				endcase
			end
		end
	end

	// Open-drain: the level is always low, only the enable moves.
	assign sda_o = 1'b0;
	assign sda_oe_o = oe_r;
	assign ptr_o = ptr_r;
	assign wr_stb_o = wr_stb_r;
	assign wr_addr_o = wr_addr_r;
	assign wr_data_o = wr_data_r;
	assign wrap_o = wrap_r;

endmodule

/* File: verif/apmc_host.sv */
`timescale 1ns/1ps
// Host end of the serial control port; data line is open drain.
module apmc_host import apmc_pkg::*; (
	input wire logic clock_i,
	input wire logic sda_i,
	output logic scl_o,
	output logic sda_oe_o,
	output logic rd_valid_o,
	output logic [7:0] rd_byte_o
);
	// Idle bus has the clock driven high and the data line released, so the pull-up holds it high.
	initial begin
		scl_o = 1'b1;
		sda_oe_o = 1'b0;
		rd_valid_o = 1'b0;
		rd_byte_o = 8'h00;
	end

	// Every change lands on a falling edge, away from the sampling edge.
	task automatic hold(input int n);
		repeat (n) @(negedge clock_i);
	endtask

	// Eight clocks per half bit leave margin over the pin synchronisers.
	task automatic bit_io(input logic b, output logic s);
		sda_oe_o = !b;
		hold(4);
		scl_o = 1'b1;
		hold(4);
		s = sda_i;
		hold(4);
		scl_o = 1'b0;
		hold(4);
	endtask

	// Also serves as a repeated start when the clock line is low.
	task automatic start();
		sda_oe_o = 1'b0;
		hold(4);
		scl_o = 1'b1;
		hold(8);
		sda_oe_o = 1'b1;
		hold(8);
		scl_o = 1'b0;
		hold(4);
	endtask

	task automatic stop();
		sda_oe_o = 1'b1;
		hold(4);
		scl_o = 1'b1;
		hold(8);
		sda_oe_o = 1'b0;
		hold(8);
	endtask

	// Sending all ones releases the line, so the same task reads a byte.
	task automatic xfer(input logic [7:0] b, input logic last,
		output logic [7:0] got, output logic ack);
		logic s;
		for (int i = 7; i >= 0; i--) begin
			bit_io(b[i], s);
			got[i] = s;
		end
		bit_io(last, s);
		ack = !s;
	endtask

	task automatic write(input logic [6:0] dev, input logic [7:0] ofs,
		input logic [7:0] d, output logic ack);
		logic [7:0] g;
		logic a1, a2, a3;
		start();
		xfer({dev, 1'b0}, 1'b1, g, a1);
		xfer(ofs, 1'b1, g, a2);
		xfer(d, 1'b1, g, a3);
		stop();
		ack = a1 & a2 & a3;
	endtask

	// The single data byte is refused by the host, ending the read.
	task automatic read(input logic [7:0] ofs);
		logic [7:0] g;
		logic a;
		start();
		xfer({APMC_DEV_ADDR, 1'b0}, 1'b1, g, a);
		xfer(ofs, 1'b1, g, a);
		start();
		xfer({APMC_DEV_ADDR, 1'b1}, 1'b1, g, a);
		xfer(8'hFF, 1'b1, g, a);
		rd_byte_o = g;
		rd_valid_o = 1'b1;
		hold(1);
		rd_valid_o = 1'b0;
		stop();
	endtask
endmodule

/* File: verif/amp_power_mode_control_regs_test.sv */
`timescale 1ns/1ps
module amp_power_mode_control_regs_test;
	import apmc_pkg::*;
	logic clock_i = 1'b0;
	logic sys_rst_i = 1'b1;
	logic fault_i = 1'b0;
	logic scl, host_oe, sda_oe, sda_o, rd_valid, srst, bsel, pflag;
	logic mi, mv, ma;
	logic [7:0] rd_byte, page;
	logic [2:0] path;
	logic [3:0] gain;
	logic [1:0] pwr;
	logic [7:0] exp_q[$];
	logic [7:0] lfsr_r = 8'h30;
	int bad_count = 0;
	int total_checks = 0;
	int pulses = 0;
	int cycles = 0;
	wire sda = (sda_oe ? sda_o : 1'b1) & !host_oe;

	// Free-running 4 ns clock.
	initial begin
		forever #2 clock_i = ~clock_i;
	end

	apmc_regs DUT (.clock_i(clock_i), .sys_rst_i(sys_rst_i),
		.scl_i(scl), .sda_i(sda), .sda_o(sda_o), .sda_oe_o(sda_oe),
		.fault_i(fault_i), .soft_reset_o(srst), .page_o(page),
		.path_select_o(path), .boost_tracking_select_o(bsel),
		.dac_gain_o(gain), .power_state_select_o(pwr),
		.power_fault_flag_o(pflag), .current_sense_mute_o(mi),
		.voltage_sense_mute_o(mv), .playback_mute_o(ma));

	apmc_host host (.clock_i(clock_i), .sda_i(sda), .scl_o(scl),
		.sda_oe_o(host_oe), .rd_valid_o(rd_valid), .rd_byte_o(rd_byte));

	function automatic logic [7:0] lfsr(input logic [7:0] v);
		return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
	endfunction

	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		total_checks++;
		if (seen !== exp) begin
			bad_count++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic close_out();
		if (bad_count == 0 && total_checks > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask

	task automatic wr(input logic [7:0] ofs, input logic [7:0] d);
		logic a;
		host.write(APMC_DEV_ADDR, ofs, d, a);
	endtask

	// The expectation is queued before the read so the monitor finds it.
	task automatic rd(input logic [7:0] ofs, input logic [7:0] e);
		exp_q.push_back(e);
		host.read(ofs);
	endtask

	// Read data is judged against the oldest note when it is delivered.
	always @(posedge clock_i) begin
		if (rd_valid === 1'b1) begin
			check(rd_byte, exp_q.pop_front());
		end
	end

	// Soft reset pulses and the run ceiling are counted every clock.
	always @(posedge clock_i) begin
		cycles++;
		if (srst === 1'b1) begin
			pulses++;
		end
		if (cycles == 60000) begin
			bad_count++;
			close_out();
		end
	end

	// Main sequence: reset values, legal codes of each field, fault, paging.
	initial begin
		logic [7:0] v, m;
		int i;
		host.hold(12);
		sys_rst_i = 1'b0;
		host.hold(4);
		rd(APMC_OFS_MODE, 8'h01);
		rd(APMC_OFS_SPK, 8'h5F);
		rd(APMC_OFS_PWR2, 8'h00);
		rd(APMC_OFS_PWR1, 8'h00);
		// The host never writes a reserved path code, so only 1 to 5 go out.
		for (i = 0; i < 8; i++) begin
			v = {5'h00, 3'((i % 5) + 1)};
			wr(APMC_OFS_MODE, v);
			check({5'h00, path}, v);
			rd(APMC_OFS_MODE, v);
		end
		for (i = 0; i < 4; i++) begin
			m = (i == 0) ? 8'h00 : (i == 1) ? 8'h0F : {4'h0, lfsr_r[3:0]};
			lfsr_r = lfsr(lfsr_r);
			v = {3'h2, i[0], m[3:0]};
			wr(APMC_OFS_SPK, v);
			check({7'h00, bsel}, {7'h00, v[4]});
			check({4'h0, gain}, m);
			rd(APMC_OFS_SPK, v);
		end
		// Power codes cycle through the three legal states only.
		for (i = 1; i < 5; i++) begin
			m = {5'h00, lfsr_r[2:0]};
			lfsr_r = lfsr(lfsr_r);
			v = {2'(i % 3), 3'h0, m[2:0]};
			wr(APMC_OFS_PWR1, v);
			check({6'h00, pwr}, {6'h00, v[7:6]});
			check({5'h00, mi, mv, ma}, m);
			rd(APMC_OFS_PWR1, v);
		end
		wr(APMC_OFS_PWR1, 8'h40);
		fault_i = 1'b1;
		host.hold(6);
		check({6'h00, pwr}, 8'h00);
		check({7'h00, pflag}, 8'h01);
		rd(APMC_OFS_PWR1, 8'h00);
		fault_i = 1'b0;
		rd(APMC_OFS_PWR2, 8'h01);
		wr(APMC_OFS_PWR2, 8'h00);
		rd(APMC_OFS_PWR2, 8'h00);
		wr(APMC_OFS_MODE, 8'h81);
		wr(8'h7F, 8'h00);
		check(page, 8'h01);
		rd(APMC_OFS_MODE, 8'h00);
		rd(APMC_OFS_PAGE, 8'h01);
		wr(APMC_OFS_PAGE, 8'h00);
		wr(APMC_OFS_MODE, 8'h01);
		wr(8'h7F, 8'h00);
		check(page, 8'h00);
		wr(APMC_OFS_SPK, 8'h40);
		wr(APMC_OFS_RESET, 8'h01);
		check(8'(pulses), 8'h01);
		rd(APMC_OFS_RESET, 8'h00);
		rd(APMC_OFS_SPK, 8'h5F);
		host.hold(20);
		check(8'(exp_q.size()), 8'h00);
		close_out();
	end
endmodule
